// [inc/lmcfg_map.svh]
// Overview of operation
// - lock asserts after 1024..8192 in-window cycles
// - lost reference drops lock when enabled
// - bit 5 selects bleed current polarity
// - optional resync of select pin to reference
// - readback select: calibration data or version
// - half lsb added when bit 5 set, aux modulator off and integer mode off
// - mask bit suppresses modulator reset on write
// - mode bit one disables modulator, integer mode
// - amplitude loop off bit stops bias control
// - bit 1 enables temperature calibration voltage
// - core d rectifier, range, nominal threshold
// - core c rectifier bias select bit 4
`ifndef LMCFG_MAP_SVH
`define LMCFG_MAP_SVH
`define LMCFG_ADDR_LOCK     8'h28
`define LMCFG_ADDR_RBSYNC   8'h2a
`define LMCFG_ADDR_SDM      8'h2b
`define LMCFG_ADDR_CORED    8'h2c
`define LMCFG_ADDR_COREC    8'h2d
`define LMCFG_ADDR_FRAC     8'h10
`define LMCFG_RST_LOCK      8'h03
`define LMCFG_RST_RBSYNC    8'h00
`define LMCFG_RST_SDM       8'h01
`define LMCFG_RST_CORED     8'h44
`define LMCFG_RST_COREC     8'h11
`define LMCFG_MASK_LOCK     8'h07
`define LMCFG_MASK_RBSYNC   8'h29
`define LMCFG_MASK_SDM      8'h35
`define LMCFG_MASK_CORED    8'h7f
`define LMCFG_MASK_COREC    8'h10
`define LMCFG_LOCK_BASE     14'h0400
`define LMCFG_REF_LOSS_CYC  16'h0100
`endif

// [inc/lmcfg_pkg.sv]
package lmcfg_pkg;
	typedef enum logic [1:0] {
		LMCFG_SER_IDLE,
		LMCFG_SER_SHIFT,
		LMCFG_SER_DONE
	} lmcfg_ser_t;
endpackage : lmcfg_pkg

// [design/lmcfg_sync.sv]
`timescale 1ns/10ps
module lmcfg_sync (
	input  wire logic clk_sys,
	input  wire logic rst_b,
	input  wire logic async_in,
	output logic      sync_out
);
	logic stage1_reg;
	logic stage2_reg;
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			stage1_reg <= 1'b0;
			stage2_reg <= 1'b0;
		end else begin
			stage1_reg <= async_in;
			stage2_reg <= stage1_reg;
		end
	end
	assign sync_out = stage2_reg;
endmodule : lmcfg_sync

// [design/lmcfg_top.sv]
`timescale 1ns/10ps
`include "lmcfg_map.svh"
module lmcfg_top
	import lmcfg_pkg::*;
#(
	parameter logic [15:0] REF_LOSS_CYC = `LMCFG_REF_LOSS_CYC,
	parameter logic [7:0]  VERSION_ID   = 8'h5a // arbitrary value
) (
	input  wire logic clk_sys,
	input  wire logic rst_b,
	input  wire logic serial_select_pin,
	input  wire logic serial_clk,
	input  wire logic serial_data_in,
	output logic      serial_data_out,
	input  wire logic reference_input_neg,
	input  wire logic phase_in_window,
	input  wire logic [7:0] cal_readback_data,
	output logic      lock_detect,
	output logic      bleed_polarity,
	output logic      modulator_integer_mode,
	output logic      aux_modulator_enable,
	output logic      half_lsb_active,
	output logic      modulator_reset,
	output logic      amplitude_loop_off,
	output logic      temp_cal_voltage_enable,
	output logic      rectifier_bias_core_d,
	output logic      threshold_range_core_d,
	output logic [2:0] nominal_threshold_core_d,
	output logic      rectifier_bias_core_c
);
	logic rst_s1_reg;
	logic rst_sync_b;
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			rst_s1_reg <= 1'b0;
			rst_sync_b <= 1'b0;
		end else begin
			rst_s1_reg <= 1'b1;
			rst_sync_b <= rst_s1_reg;
		end
	end

	// serial port: select low frames 16 bits, msb first: r/w, 7-bit addr, 8 data
	logic sel_sync;
	logic sel_act_sync;
	logic sel_ref_reg;
	logic sel_ref_next;
	logic sel_used;
	logic ref_prev_reg;
	logic ref_rise;
	logic sclk_prev_reg;
	logic sclk_rise;
	logic sclk_fall;
	lmcfg_ser_t ser_reg;
	lmcfg_ser_t ser_next;
	logic [4:0]  bit_cnt_reg;
	logic [4:0]  bit_cnt_next;
	logic [15:0] shift_reg;
	logic [15:0] shift_next;
	logic [7:0]  rd_shift_reg;
	logic [7:0]  rd_shift_next;
	logic        sdo_reg;
	logic        sdo_next;
	logic        wr_stb;

	lmcfg_sync u_sel_sync (
		.clk_sys  (clk_sys),
		.rst_b    (rst_sync_b),
		.async_in (~serial_select_pin),
		.sync_out (sel_act_sync)
	);
	// active copy resets deselected, no false frame
	assign sel_sync = ~sel_act_sync;

	assign ref_rise  = reference_input_neg & ~ref_prev_reg;
	assign sclk_rise = serial_clk & ~sclk_prev_reg;
	assign sclk_fall = ~serial_clk & sclk_prev_reg;

	logic [7:0] lock_cfg_reg;
	logic [7:0] rbsync_reg;
	logic [7:0] sdm_reg;
	logic [7:0] cored_reg;
	logic [7:0] corec_reg;
	logic [7:0] lock_cfg_next;
	logic [7:0] rbsync_next;
	logic [7:0] sdm_next;
	logic [7:0] cored_next;
	logic [7:0] corec_next;
	logic [7:0] rd_data;
	logic [6:0] acc_addr;
	logic       half_lsb_reg;
	logic       half_lsb_next;

	always_comb begin
		sel_ref_next = sel_ref_reg;
		if (ref_rise) begin
			sel_ref_next = sel_sync;
		end
	end
	assign sel_used = rbsync_reg[3] ? sel_ref_reg : sel_sync;
	// address at the 8th rise: six shifted bits plus the pin
	assign acc_addr = {shift_reg[5:0], serial_data_in};

	always_comb begin
		rd_data = rbsync_reg[0] ? VERSION_ID : cal_readback_data;
		case ({1'b0, acc_addr})
			`LMCFG_ADDR_LOCK:   rd_data = lock_cfg_reg;
			`LMCFG_ADDR_RBSYNC: rd_data = rbsync_reg;
			`LMCFG_ADDR_SDM:    rd_data = sdm_reg;
			`LMCFG_ADDR_CORED:  rd_data = cored_reg;
			`LMCFG_ADDR_COREC:  rd_data = corec_reg;
			default:            ;
		endcase
	end

	always_comb begin
		ser_next      = ser_reg;
		bit_cnt_next  = bit_cnt_reg;
		shift_next    = shift_reg;
		rd_shift_next = rd_shift_reg;
		sdo_next      = sdo_reg;
		wr_stb        = 1'b0;
		case (ser_reg)
			LMCFG_SER_IDLE: begin
				bit_cnt_next = 5'h00;
				sdo_next     = 1'b0;
				if (!sel_used) begin
					ser_next = LMCFG_SER_SHIFT;
				end
			end
			LMCFG_SER_SHIFT: begin
				if (sel_used) begin
					ser_next = LMCFG_SER_IDLE;
				end else if (sclk_rise) begin
					shift_next   = {shift_reg[14:0], serial_data_in};
					bit_cnt_next = bit_cnt_reg + 5'h01;
					if (bit_cnt_reg == 5'h07) begin
						rd_shift_next = rd_data;
					end
					if (bit_cnt_reg == 5'h0f) begin
						ser_next = LMCFG_SER_DONE;
					end
				end else if (sclk_fall && bit_cnt_reg >= 5'h08) begin
					sdo_next      = rd_shift_reg[7];
					rd_shift_next = {rd_shift_reg[6:0], 1'b0};
				end
			end
			LMCFG_SER_DONE: begin
				wr_stb   = ~shift_reg[15];
				ser_next = LMCFG_SER_IDLE;
			end
			default: ser_next = LMCFG_SER_IDLE;
		endcase
	end

	always_comb begin
		lock_cfg_next = lock_cfg_reg;
		rbsync_next   = rbsync_reg;
		sdm_next      = sdm_reg;
		cored_next    = cored_reg;
		corec_next    = corec_reg;
		if (wr_stb) begin
			case ({1'b0, shift_reg[14:8]})
				`LMCFG_ADDR_LOCK:   lock_cfg_next = shift_reg[7:0] & `LMCFG_MASK_LOCK;
				`LMCFG_ADDR_RBSYNC: rbsync_next   = shift_reg[7:0] & `LMCFG_MASK_RBSYNC;
				`LMCFG_ADDR_SDM:    sdm_next      = shift_reg[7:0] & `LMCFG_MASK_SDM;
				`LMCFG_ADDR_CORED:  cored_next    = shift_reg[7:0] & `LMCFG_MASK_CORED;
				`LMCFG_ADDR_COREC:  corec_next    = shift_reg[7:0] & `LMCFG_MASK_COREC;
				default:            ;
			endcase
		end
		// half lsb from new mode bits
		half_lsb_next = sdm_next[5] & ~sdm_next[4] & ~sdm_next[0];
	end

	// lock detector
	logic [13:0] lock_cnt_reg;
	logic [13:0] lock_cnt_next;
	logic [15:0] loss_cnt_reg;
	logic [15:0] loss_cnt_next;
	logic        lock_reg;
	logic        lock_next;
	logic [13:0] lock_target;
	logic        ref_lost;

	assign lock_target = `LMCFG_LOCK_BASE << lock_cfg_reg[2:1];
	assign ref_lost    = (loss_cnt_reg >= REF_LOSS_CYC);

	always_comb begin
		lock_cnt_next = lock_cnt_reg;
		lock_next     = lock_reg;
		loss_cnt_next = ref_rise ? 16'h0000 : loss_cnt_reg;
		if (!ref_rise && !ref_lost) begin
			loss_cnt_next = loss_cnt_reg + 16'h0001;
		end
		if (ref_rise) begin
			if (!phase_in_window) begin
				lock_cnt_next = 14'h0000;
				lock_next     = 1'b0;
			end else if (!lock_reg) begin
				if (lock_cnt_reg + 14'h0001 >= lock_target) begin
					lock_next = 1'b1;
				end else begin
					lock_cnt_next = lock_cnt_reg + 14'h0001;
				end
			end
		end
		if (ref_lost && lock_cfg_reg[0] && lock_reg) begin
			lock_next     = 1'b0;
			lock_cnt_next = 14'h0000;
		end
	end

	// write to fraction word resets modulator unless masked
	logic mod_rst_reg;
	logic mod_rst_next;
	assign mod_rst_next = wr_stb && ({1'b0, shift_reg[14:8]} == `LMCFG_ADDR_FRAC) && !sdm_reg[2];

	// serial port state
	always_ff @(posedge clk_sys or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			sel_ref_reg   <= 1'b1;
			ref_prev_reg  <= 1'b0;
			sclk_prev_reg <= 1'b0;
			ser_reg       <= LMCFG_SER_IDLE;
			bit_cnt_reg   <= 5'h00;
			shift_reg     <= 16'h0000;
			rd_shift_reg  <= 8'h00;
			sdo_reg       <= 1'b0;
		end else begin
			sel_ref_reg   <= sel_ref_next;
			ref_prev_reg  <= reference_input_neg;
			sclk_prev_reg <= serial_clk;
			ser_reg       <= ser_next;
			bit_cnt_reg   <= bit_cnt_next;
			shift_reg     <= shift_next;
			rd_shift_reg  <= rd_shift_next;
			sdo_reg       <= sdo_next;
		end
	end

	// register bank
	always_ff @(posedge clk_sys or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			lock_cfg_reg  <= `LMCFG_RST_LOCK;
			rbsync_reg    <= `LMCFG_RST_RBSYNC;
			sdm_reg       <= `LMCFG_RST_SDM;
			cored_reg     <= `LMCFG_RST_CORED;
			corec_reg     <= `LMCFG_RST_COREC;
			half_lsb_reg  <= 1'b0;
		end else begin
			lock_cfg_reg  <= lock_cfg_next;
			rbsync_reg    <= rbsync_next;
			sdm_reg       <= sdm_next;
			cored_reg     <= cored_next;
			corec_reg     <= corec_next;
			half_lsb_reg  <= half_lsb_next;
		end
	end

	// lock detector state
	always_ff @(posedge clk_sys or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			lock_cnt_reg  <= 14'h0000;
			loss_cnt_reg  <= 16'h0000;
			lock_reg      <= 1'b0;
		end else begin
			lock_cnt_reg  <= lock_cnt_next;
			loss_cnt_reg  <= loss_cnt_next;
			lock_reg      <= lock_next;
		end
	end

	// modulator reset pulse
	always_ff @(posedge clk_sys or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			mod_rst_reg   <= 1'b0;
		end else begin
			mod_rst_reg   <= mod_rst_next;
		end
	end

	assign serial_data_out = sdo_reg;
	assign lock_detect     = lock_reg;
	assign modulator_reset = mod_rst_reg;
	assign bleed_polarity  = rbsync_reg[5];
	assign modulator_integer_mode = sdm_reg[0];
	assign aux_modulator_enable   = sdm_reg[4];
	// half lsb only with aux off
	assign half_lsb_active        = half_lsb_reg;
	assign amplitude_loop_off       = cored_reg[0];
	assign temp_cal_voltage_enable  = cored_reg[1];
	assign rectifier_bias_core_d    = cored_reg[6];
	assign threshold_range_core_d   = cored_reg[5];
	assign nominal_threshold_core_d = cored_reg[4:2];
	assign rectifier_bias_core_c    = corec_reg[4];
endmodule : lmcfg_top

// [verif/lmcfg_asserts.sv]
`timescale 1ns/10ps
module lmcfg_asserts (
	input wire logic clk_sys,
	input wire logic rst_b,
	input wire logic serial_select_pin,
	input wire logic phase_in_window,
	input wire logic lock_detect,
	input wire logic bleed_polarity,
	input wire logic modulator_integer_mode,
	input wire logic aux_modulator_enable,
	input wire logic half_lsb_active,
	input wire logic modulator_reset,
	input wire logic amplitude_loop_off
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_b);
	logic [12:0] low_cnt_reg;
	logic [12:0] low_cnt_next;
	logic [6:0]  out_cnt_reg;
	logic [6:0]  out_cnt_next;
	// cycles since lock low, cycles out of window
	always_comb begin
		low_cnt_next = lock_detect ? 13'h0000 : low_cnt_reg + {12'h000, ~&low_cnt_reg};
		out_cnt_next = phase_in_window ? 7'h00 : out_cnt_reg + {6'h00, ~&out_cnt_reg};
	end
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			low_cnt_reg <= 13'h0000;
			out_cnt_reg <= 7'h00;
		end else begin
			low_cnt_reg <= low_cnt_next;
			out_cnt_reg <= out_cnt_next;
		end
	end
	reset_vals_a: assert property ($rose(rst_b) |-> modulator_integer_mode && !bleed_polarity
		&& !aux_modulator_enable && !amplitude_loop_off) else $error("outputs not at reset values");
	lock_qual_a: assert property ($rose(lock_detect) |-> low_cnt_reg >= 13'h0800)
		else $error("lock asserted too early");
	lock_window_a: assert property (out_cnt_reg >= 7'h40 |-> !lock_detect)
		else $error("lock held while out of window");
	aux_half_a: assert property (half_lsb_active |-> !aux_modulator_enable)
		else $error("half lsb with aux modulator on");
	int_half_a: assert property (half_lsb_active |-> !modulator_integer_mode)
		else $error("half lsb in integer mode");
	mod_pulse_a: assert property (modulator_reset |=> !modulator_reset)
		else $error("modulator reset longer than one cycle");
	mod_frame_a: assert property (modulator_reset |-> !$past(serial_select_pin, 4))
		else $error("modulator reset outside a frame");
	cfg_frame_a: assert property ($changed({bleed_polarity, amplitude_loop_off,
		aux_modulator_enable, modulator_integer_mode}) |-> !$past(serial_select_pin, 4))
		else $error("config changed outside a frame");
	lock_c: cover property ($rose(lock_detect));
	mod_c: cover property (modulator_reset);
	half_c: cover property (half_lsb_active);
endmodule : lmcfg_asserts

bind lmcfg_top lmcfg_asserts u_lmcfg_asserts (.clk_sys, .rst_b, .serial_select_pin,
	.phase_in_window, .lock_detect, .bleed_polarity, .modulator_integer_mode,
	.aux_modulator_enable, .half_lsb_active, .modulator_reset, .amplitude_loop_off);

// [verif/tb_lmcfg_top.sv]
`timescale 1ns/10ps
module tb_lmcfg_top;
	logic clk_sys = 1'b0, rst_b = 1'b0, serial_select_pin = 1'b1, serial_clk = 1'b0;
	logic serial_data_in = 1'b0, reference_input_neg = 1'b0, phase_in_window = 1'b0;
	logic [7:0] cal_readback_data = 8'hc3;
	logic serial_data_out, lock_detect, bleed_polarity, modulator_integer_mode;
	logic aux_modulator_enable, half_lsb_active, modulator_reset, amplitude_loop_off;
	logic temp_cal_voltage_enable, rectifier_bias_core_d, threshold_range_core_d;
	logic rectifier_bias_core_c, ref_run = 1'b1;
	logic [2:0] nominal_threshold_core_d, ph = 3'h0;
	logic [7:0] rd, v;
	logic [7:0] adr [5] = '{8'h28, 8'h2a, 8'h2b, 8'h2c, 8'h2d};
	logic [7:0] rstv [5] = '{8'h03, 8'h00, 8'h01, 8'h44, 8'h11};
	logic [7:0] msk [5] = '{8'h07, 8'h29, 8'h35, 8'h7f, 8'h10};
	int miscompares = 0, checked = 0, cyc = 0, pulses = 0, p0;
	lmcfg_top #(.REF_LOSS_CYC(16'h0010), .VERSION_ID(8'h5a)) u_lmcfg_top (.clk_sys, .rst_b,
		.serial_select_pin,
		.serial_clk, .serial_data_in, .serial_data_out, .reference_input_neg, .phase_in_window,
		.cal_readback_data, .lock_detect, .bleed_polarity, .modulator_integer_mode,
		.aux_modulator_enable, .half_lsb_active, .modulator_reset, .amplitude_loop_off,
		.temp_cal_voltage_enable, .rectifier_bias_core_d, .threshold_range_core_d,
		.nominal_threshold_core_d, .rectifier_bias_core_c);
	initial forever #2.5 clk_sys = ~clk_sys;
	always @(posedge clk_sys) begin
		cyc <= cyc + 1;
		if (ref_run) ph <= ph + 3'h1;
		reference_input_neg <= ph[1];
		if (modulator_reset === 1'b1) pulses <= pulses + 1;
		if (cyc == 95000) begin
			miscompares = miscompares + 1;
			test_done();
		end
	end
	task tick(input int n);
		repeat (n) @(posedge clk_sys);
	endtask : tick
	task cmp(input logic [7:0] seen, input logic [7:0] exp);
		checked++;
		if (seen !== exp) begin
			miscompares++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : cmp
	task xfer(input logic r, input logic [7:0] a, input logic [7:0] d);
		logic [15:0] w;
		w = {r, a[6:0], d};
		tick(1);
		serial_select_pin <= 1'b0;
		for (int i = 15; i >= 0; i--) begin
			tick(6);
			serial_clk <= 1'b0;
			serial_data_in <= w[i];
			tick(6);
			if (i < 8) rd[i] = serial_data_out;
			serial_clk <= 1'b1;
		end
		tick(6);
		serial_clk <= 1'b0;
		tick(12);
		serial_select_pin <= 1'b1;
		tick(8);
	endtask : xfer
	task test_done;
		$display("checks %0d mismatches %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask : test_done
	initial begin
		tick(12);
		rst_b <= 1'b1;
		tick(4);
		for (int k = 0; k < 5; k++) begin
			xfer(1'b1, adr[k], 8'h00);
			cmp(rd, rstv[k]);
		end
		$display("reset values done");
		for (int j = 0; j < 2; j++) begin
			v = j ? 8'h00 : 8'hff;
			for (int k = 0; k < 5; k++) begin
				xfer(1'b0, adr[k], v);
				xfer(1'b1, adr[k], 8'h00);
				cmp(rd, v & msk[k]);
			end
			cmp({bleed_polarity, amplitude_loop_off, temp_cal_voltage_enable, rectifier_bias_core_d,
				threshold_range_core_d, nominal_threshold_core_d}, v);
			cmp({5'h00, rectifier_bias_core_c, aux_modulator_enable, modulator_integer_mode},
				v & 8'h07);
		end
		$display("field write done");
		xfer(1'b0, 8'h2a, 8'h01);
		xfer(1'b1, 8'h7f, 8'h00);
		cmp(rd, 8'h5a);
		xfer(1'b0, 8'h2a, 8'h00);
		xfer(1'b1, 8'h7f, 8'h00);
		cmp(rd, 8'hc3);
		xfer(1'b0, 8'h2a, 8'h08);
		ref_run <= 1'b0;
		xfer(1'b0, 8'h2c, 8'h7f);
		ref_run <= 1'b1;
		xfer(1'b0, 8'h2a, 8'h00);
		xfer(1'b1, 8'h2c, 8'h00);
		cmp(rd, 8'h00);
		$display("select sync done");
		for (int k = 0; k < 3; k++) begin
			xfer(1'b0, 8'h2b, k == 0 ? 8'h20 : (k == 1 ? 8'h30 : 8'h21));
			cmp({7'h00, half_lsb_active}, {7'h00, k == 0});
		end
		for (int k = 0; k < 2; k++) begin
			xfer(1'b0, 8'h2b, k ? 8'h04 : 8'h00);
			p0 = pulses;
			xfer(1'b0, 8'h10, 8'h55);
			cmp(8'(pulses - p0), k ? 8'h00 : 8'h01);
		end
		$display("modulator done");
		for (int c = 0; c < 4; c++) begin
			xfer(1'b0, 8'h28, {5'h00, c[1:0], 1'b1});
			phase_in_window <= 1'b0;
			tick(40);
			phase_in_window <= 1'b1;
			tick((4096 << c) - 40);
			cmp({7'h00, lock_detect}, 8'h00);
			tick(200);
			cmp({7'h00, lock_detect}, 8'h01);
		end
		ref_run <= 1'b0;
		tick(40);
		cmp({7'h00, lock_detect}, 8'h00);
		xfer(1'b0, 8'h28, 8'h00);
		ref_run <= 1'b1;
		tick(4200);
		ref_run <= 1'b0;
		tick(60);
		cmp({7'h00, lock_detect}, 8'h01);
		ref_run <= 1'b1;
		phase_in_window <= 1'b0;
		tick(40);
		cmp({7'h00, lock_detect}, 8'h00);
		$display("lock done");
		test_done();
	end
endmodule : tb_lmcfg_top
